// file: rtl/smc_defs.vh
// What this block does
// - Decode sleep mode codes; 100, 101 reserved
// - Sleep instruction sleeps only when armed
// - Debug port on when bit zero, fuse set
// - Debug disable changes on double write
// - Brownout off needs unlock then write
// - Brownout off active three cycles, self-clears
// - Detector off only if sleeping while active
// - Pull-up kill turns off all pull-ups
// - Vector base at flash or boot start
// - Vector select needs unlock then write
// - Block interrupts during vector change sequence
// - Blocking leaves global interrupt flag untouched
// - Vector unlock clears after four cycles
// - Boot vectors plus app lock block app
// - App vectors plus boot lock block boot
// - Input buffers off when io, converter stopped
// - Debug fuse keeps main clock in sleep
// - Reference on only when a user needs it
// - Enabled watchdog keeps running in sleep
// - Registers at 0x53, 0x55; io minus 0x20
// - Standby wake resumes within six cycles
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
`define SMC_ADDR_SLEEP    8'h53
`define SMC_ADDR_SYS      8'h55
`define SMC_IO_OFFSET     8'h20
`define SMC_RESET_VAL     8'h00
`define SMC_SYS_WMASK     8'hF3
`define SMC_SYS_RMASK     8'hF3
`define SMC_SLP_RMASK     8'h0F
`define SMC_BIT_ARM       0
`define SMC_BIT_JTD       7
`define SMC_BIT_BOFF      6
`define SMC_BIT_BUNL      5
`define SMC_BIT_PUK       4
`define SMC_BIT_VSEL      1
`define SMC_BIT_VUNL      0
`define SMC_MODE_IDLE     3'h0
`define SMC_MODE_ADCNR    3'h1
`define SMC_MODE_PDOWN    3'h2
`define SMC_MODE_PSAVE    3'h3
`define SMC_MODE_STBY     3'h6
`define SMC_MODE_XSTBY    3'h7
`define SMC_WIN_CYC       3'h4
`define SMC_BOFF_CYC      3'h3
`define SMC_WAKE_CYC      3'h6
`endif

// file: rtl/smc_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.vh"
module smc_regs (
  input  wire       clk,
  input  wire       reset,
  input  wire [7:0] addr,
  input  wire       io_space,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata,
  output wire       hit,
  input  wire       sleep_instr,
  input  wire       wake,
  input  wire       instr_done,
  input  wire       jtag_enable_fuse,
  input  wire       debug_enable_fuse,
  input  wire       app_lock_bit,
  input  wire       boot_lock_bit,
  input  wire       exec_in_boot,
  input  wire [15:0] boot_start,
  input  wire       bod_fuse_on,
  input  wire       comp_on,
  input  wire       adc_on,
  input  wire       wdt_on,
  output reg        sleeping,
  output reg  [2:0] active_mode,
  output wire       cpu_resume,
  output wire       bod_off_sleep,
  output wire       jtag_port_en,
  output wire       pullup_kill,
  output wire [15:0] vector_base,
  output wire       irq_block,
  output wire       input_buf_off,
  output wire       main_clk_keep,
  output wire       vref_en,
  output wire       wdt_run
);
  reg  [7:0] sleep_mode_control;
  reg  [7:0] system_control;
  reg  [2:0] jtd_cnt;
  reg        jtd_pend;
  reg  [2:0] bunl_cnt;
  reg  [2:0] boff_cnt;
  reg        boff_act;
  reg  [2:0] vunl_cnt;
  reg        vsel_written;
  reg        blk_tail;
  reg        bod_off_r;
  reg  [2:0] wake_cnt;
  wire [7:0] eff_addr;
  wire       sel_slp;
  wire       sel_sys;
  wire       w_slp;
  wire       w_sys;
  wire       mode_ok;

  function valid_mode;
    input [2:0] m;
    begin
      valid_mode = (m != 3'h4) && (m != 3'h5);
    end
  endfunction

  function clk_io_adc_stopped;
    input [2:0] m;
    begin
      clk_io_adc_stopped = (m == `SMC_MODE_PDOWN) || (m == `SMC_MODE_PSAVE) ||
                           (m == `SMC_MODE_STBY) || (m == `SMC_MODE_XSTBY);
    end
  endfunction

  assign eff_addr = io_space ? (addr + `SMC_IO_OFFSET) : addr;
  assign sel_slp  = (eff_addr == `SMC_ADDR_SLEEP);
  assign sel_sys  = (eff_addr == `SMC_ADDR_SYS);
  assign hit      = sel_slp | sel_sys;
  assign w_slp    = wr_en & sel_slp;
  assign w_sys    = wr_en & sel_sys;
  assign mode_ok  = valid_mode(sleep_mode_control[3:1]);

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata <= `SMC_RESET_VAL;
    else if (rd_en)
      rdata <= sel_slp ? (sleep_mode_control & `SMC_SLP_RMASK) :
               sel_sys ? (system_control & `SMC_SYS_RMASK) : 8'h00;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      sleep_mode_control <= `SMC_RESET_VAL;
    else if (w_slp)
      sleep_mode_control <= wdata & `SMC_SLP_RMASK;
  end

  // Debug disable: second equal write within window commits
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      jtd_cnt  <= 3'h0;
      jtd_pend <= 1'b0;
    end
    else if (w_sys)
    begin
      if (jtd_cnt != 3'h0 && jtd_pend == wdata[`SMC_BIT_JTD])
        jtd_cnt <= 3'h0;
      else
      begin
        jtd_cnt  <= `SMC_WIN_CYC;
        jtd_pend <= wdata[`SMC_BIT_JTD];
      end
    end
    else if (jtd_cnt != 3'h0)
      jtd_cnt <= jtd_cnt - 3'h1;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      system_control <= `SMC_RESET_VAL;
      bunl_cnt       <= 3'h0;
      boff_cnt       <= 3'h0;
      boff_act       <= 1'b0;
      vunl_cnt       <= 3'h0;
      vsel_written   <= 1'b0;
    end
    else
    begin
      if (bunl_cnt != 3'h0)
        bunl_cnt <= bunl_cnt - 3'h1;
      if (vunl_cnt != 3'h0)
        vunl_cnt <= vunl_cnt - 3'h1;
      // Unlock visible for exactly the four-cycle select window
      if (vunl_cnt == 3'h1)
        system_control[`SMC_BIT_VUNL] <= 1'b0;
      if (boff_cnt != 3'h0)
      begin
        boff_cnt <= boff_cnt - 3'h1;
        if (boff_cnt == 3'h1)
        begin
          if (!boff_act)
          begin
            boff_act <= 1'b1;
            boff_cnt <= `SMC_BOFF_CYC;
          end
          else
          begin
            boff_act <= 1'b0;
            system_control[`SMC_BIT_BOFF] <= 1'b0;
          end
        end
      end
      if (instr_done)
        vsel_written <= 1'b0;
      if (w_sys)
      begin
        system_control[`SMC_BIT_PUK] <= wdata[`SMC_BIT_PUK];
        if (jtd_cnt != 3'h0 && jtd_pend == wdata[`SMC_BIT_JTD])
          system_control[`SMC_BIT_JTD] <= wdata[`SMC_BIT_JTD];
        if (wdata[`SMC_BIT_BOFF] && wdata[`SMC_BIT_BUNL])
        begin
          bunl_cnt <= `SMC_WIN_CYC;
          system_control[`SMC_BIT_BUNL] <= 1'b1;
        end
        else
        begin
          system_control[`SMC_BIT_BUNL] <= 1'b0;
          if (wdata[`SMC_BIT_BOFF] && bunl_cnt != 3'h0)
          begin
            system_control[`SMC_BIT_BOFF] <= 1'b1;
            boff_cnt <= `SMC_BOFF_CYC;
            boff_act <= 1'b0;
          end
        end
        if (wdata[`SMC_BIT_VUNL])
        begin
          system_control[`SMC_BIT_VUNL] <= 1'b1;
          vunl_cnt <= `SMC_WIN_CYC;
        end
        else if (vunl_cnt != 3'h0)
        begin
          system_control[`SMC_BIT_VSEL] <= wdata[`SMC_BIT_VSEL];
          system_control[`SMC_BIT_VUNL] <= 1'b0;
          vunl_cnt     <= 3'h0;
          vsel_written <= 1'b1;
        end
      end
      if (bunl_cnt == 3'h1 && !(w_sys && wdata[`SMC_BIT_BUNL]))
        system_control[`SMC_BIT_BUNL] <= 1'b0;
    end
  end

  // Hold the block through the instruction after the select write
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      blk_tail <= 1'b0;
    else if (vsel_written && instr_done)
      blk_tail <= 1'b1;
    else if (instr_done)
      blk_tail <= 1'b0;
  end

  // Sleep entry, brownout latch and wake delay
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sleeping    <= 1'b0;
      active_mode <= `SMC_MODE_IDLE;
      bod_off_r   <= 1'b0;
      wake_cnt    <= 3'h0;
    end
    else if (sleeping)
    begin
      if (wake)
      begin
        sleeping  <= 1'b0;
        bod_off_r <= 1'b0;
        if (active_mode == `SMC_MODE_STBY || active_mode == `SMC_MODE_XSTBY)
          wake_cnt <= `SMC_WAKE_CYC;
      end
    end
    else
    begin
      if (wake_cnt != 3'h0)
        wake_cnt <= wake_cnt - 3'h1;
      if (sleep_instr && sleep_mode_control[`SMC_BIT_ARM] && mode_ok)
      begin
        sleeping    <= 1'b1;
        active_mode <= sleep_mode_control[3:1];
        bod_off_r   <= boff_act;
      end
    end
  end

  assign cpu_resume    = !sleeping && (wake_cnt == 3'h0);
  assign bod_off_sleep = sleeping & bod_off_r;
  assign jtag_port_en  = jtag_enable_fuse & ~system_control[`SMC_BIT_JTD];
  assign pullup_kill   = system_control[`SMC_BIT_PUK];
  assign vector_base   = system_control[`SMC_BIT_VSEL] ? boot_start : 16'h0000;
  // Gates the core's interrupt accept; status flag is not touched
  assign irq_block = system_control[`SMC_BIT_VUNL] | vsel_written | blk_tail |
                     (system_control[`SMC_BIT_VSEL] & app_lock_bit & ~exec_in_boot) |
                     (~system_control[`SMC_BIT_VSEL] & boot_lock_bit & exec_in_boot);
  assign input_buf_off = sleeping & clk_io_adc_stopped(active_mode);
  assign main_clk_keep = debug_enable_fuse;
  assign vref_en       = (bod_fuse_on & ~bod_off_sleep) | comp_on | adc_on;
  assign wdt_run       = wdt_on;
endmodule
`default_nettype wire

// file: tb/smc_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module smc_regs_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  addr,
  input wire logic        io_space,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        hit,
  input wire logic        sleep_instr,
  input wire logic        wake,
  input wire logic        jtag_enable_fuse,
  input wire logic        debug_enable_fuse,
  input wire logic [15:0] boot_start,
  input wire logic        bod_fuse_on,
  input wire logic        comp_on,
  input wire logic        adc_on,
  input wire logic        wdt_on,
  input wire logic        sleeping,
  input wire logic [2:0]  active_mode,
  input wire logic        bod_off_sleep,
  input wire logic        pullup_kill,
  input wire logic        input_buf_off,
  input wire logic        jtag_port_en,
  input wire logic [15:0] vector_base,
  input wire logic        irq_block,
  input wire logic        main_clk_keep,
  input wire logic        vref_en,
  input wire logic        wdt_run
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_vunl;
    wr_en && !io_space && addr == 8'h55 && wdata[0];
  endsequence
  sequence s_sys_wr;
    wr_en && ((!io_space && addr == 8'h55) || (io_space && addr == 8'h35));
  endsequence
  a_pud_write: assert property (s_sys_wr |=> pullup_kill == $past(wdata[4]))
    else $error("pull-up kill not written");
  a_mode_legal: assert property (sleeping |-> active_mode != 3'h4 && active_mode != 3'h5)
    else $error("sleeping in reserved mode");
  a_bod_awake: assert property (!sleeping |-> !bod_off_sleep)
    else $error("detector off while awake");
  a_buf_awake: assert property (!sleeping |-> !input_buf_off)
    else $error("input buffers off while awake");
  a_jtag_fuse_off: assert property (!jtag_enable_fuse |-> !jtag_port_en)
    else $error("jtag on without fuse");
  a_vector_base_val: assert property (vector_base == 16'h0000 || vector_base == boot_start)
    else $error("bad vector base");
  a_vunl_blocks: assert property (s_vunl |=> irq_block)
    else $error("irq not blocked");
  a_vsel_guarded: assert property ($changed(vector_base) |-> $past(irq_block))
    else $error("vector moved unguarded");
  a_sleep_cause: assert property ($rose(sleeping) |-> $past(sleep_instr))
    else $error("sleep without instr");
  a_wake_clears: assert property (wake && sleeping |=> !sleeping)
    else $error("wake ignored");
  a_vref_idle: assert property (!bod_fuse_on && !comp_on && !adc_on |-> !vref_en)
    else $error("vref on unused");
  a_wdt_keeps: assert property (wdt_on |-> wdt_run)
    else $error("wdt stopped");
  a_clk_keep: assert property (debug_enable_fuse && sleeping |-> main_clk_keep)
    else $error("main clk stopped");
  a_unmapped_rd: assert property (rd_en && !hit |=> rdata == 8'h00)
    else $error("unmapped read nonzero");
endmodule
bind smc_regs smc_regs_chk i_smc_regs_chk (.*);
`default_nettype wire

// file: tb/smc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smc_regs_tb;
  logic clk = 0, reset = 1, io_space = 0, wr_en = 0, rd_en = 0;
  logic sleep_instr = 0, wake = 0, instr_done = 0, app_lock_bit = 0, boot_lock_bit = 0;
  logic jtag_enable_fuse = 1, debug_enable_fuse = 1, exec_in_boot = 0;
  logic bod_fuse_on = 1, comp_on = 0, adc_on = 0, wdt_on = 1;
  logic [7:0] addr = 0, wdata = 0;
  logic [15:0] boot_start = 16'h7000;
  wire [7:0] rdata;
  wire [2:0] active_mode;
  wire [15:0] vector_base;
  wire hit, sleeping, cpu_resume, bod_off_sleep, jtag_port_en, pullup_kill;
  wire irq_block, input_buf_off, main_clk_keep, vref_en, wdt_run;
  integer error_cnt = 0, checked = 0;
  smc_regs i_smc_regs (.*);
  always #5 clk = ~clk;
  task chk(input [15:0] got, input [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; io_space <= 0; wr_en <= 1;
    @(posedge clk); wr_en <= 0;
  endtask
  task rd(input [7:0] a, input io, input [7:0] e);
    @(posedge clk); addr <= a; io_space <= io; rd_en <= 1;
    @(posedge clk); rd_en <= 0;
    @(negedge clk); chk(rdata, e);
  endtask
  // Sleep pulse when s is one, wake pulse otherwise
  task slp(input s);
    @(posedge clk); sleep_instr <= s; wake <= !s;
    @(posedge clk); sleep_instr <= 0; wake <= 0;
    @(negedge clk);
  endtask
  task t_regs;
    rd(8'h53, 0, 8'h00);
    rd(8'h35, 1, 8'h00);
    wr(8'h55, 8'h1C);
    rd(8'h35, 1, 8'h10);
    chk(pullup_kill, 1);
    rd(8'h54, 0, 8'h00);
    chk(hit, 0);
    wr(8'h55, 8'h00);
    @(negedge clk); chk(pullup_kill, 0);
    @(posedge clk); bod_fuse_on <= 0;
    @(negedge clk); chk(vref_en, 0);
    @(posedge clk); adc_on <= 1;
    @(negedge clk); chk(vref_en, 1);
    @(posedge clk); adc_on <= 0; bod_fuse_on <= 1;
  endtask
  task t_sleep;
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h53, {m[2:0], 1'b1});
      rd(8'h33, 1, {m[2:0], 1'b1});
      slp(1);
      chk(sleeping, m != 4 && m != 5);
      if (m != 4 && m != 5)
        chk(active_mode, m);
      chk(input_buf_off, m == 2 || m == 3 || m == 6 || m == 7);
      slp(0);
      chk(sleeping, 0);
      chk(cpu_resume, m < 6);
      repeat (6) @(negedge clk);
      chk(cpu_resume, 1);
    end
    wr(8'h53, 8'h04);
    slp(1);
    chk(sleeping, 0);
  endtask
  task t_jtag;
    wr(8'h55, 8'h80);
    rd(8'h55, 0, 8'h00);
    repeat (8) @(posedge clk);
    wr(8'h55, 8'h80);
    wr(8'h55, 8'h80);
    rd(8'h55, 0, 8'h80);
    chk(jtag_port_en, 0);
    repeat (8) @(posedge clk);
    wr(8'h55, 8'h00);
    wr(8'h55, 8'h00);
    @(negedge clk); chk(jtag_port_en, 1);
    @(posedge clk); jtag_enable_fuse <= 0;
    @(negedge clk); chk(jtag_port_en, 0);
    @(posedge clk); jtag_enable_fuse <= 1;
  endtask
  task t_brownout_sleep_off;
    wr(8'h53, 8'h05);
    wr(8'h55, 8'h40);
    rd(8'h55, 0, 8'h00);
    repeat (8) @(posedge clk);
    wr(8'h55, 8'h60);
    wr(8'h55, 8'h40);
    repeat (2) @(posedge clk);
    slp(1);
    chk(bod_off_sleep, 1);
    chk(vref_en, 0);
    chk(main_clk_keep, 1);
    chk(wdt_run, 1);
    slp(0);
    rd(8'h55, 0, 8'h00);
    slp(1);
    chk(bod_off_sleep, 0);
    slp(0);
  endtask
  task t_vec;
    @(posedge clk); boot_lock_bit <= 1; exec_in_boot <= 1;
    @(negedge clk); chk(irq_block, 1);
    @(posedge clk); boot_lock_bit <= 0; exec_in_boot <= 0;
    wr(8'h55, 8'h01);
    @(negedge clk); chk(irq_block, 1);
    wr(8'h55, 8'h02);
    rd(8'h55, 0, 8'h02);
    chk(vector_base, boot_start);
    chk(irq_block, 1);
    @(posedge clk); instr_done <= 1;
    @(posedge clk);
    @(negedge clk); chk(irq_block, 1);
    @(posedge clk); instr_done <= 0;
    @(negedge clk); chk(irq_block, 0);
    @(posedge clk); app_lock_bit <= 1;
    @(negedge clk); chk(irq_block, 1);
    @(posedge clk); exec_in_boot <= 1;
    @(negedge clk); chk(irq_block, 0);
    wr(8'h55, 8'h00);
    rd(8'h55, 0, 8'h02);
    wr(8'h55, 8'h01);
    repeat (4) @(negedge clk);
    chk(irq_block, 1);
    @(negedge clk); chk(irq_block, 0);
    rd(8'h55, 0, 8'h02);
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    error_cnt++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 0;
    t_regs;
    t_sleep;
    t_jtag;
    t_brownout_sleep_off;
    t_vec;
    results;
  end
endmodule
`default_nettype wire
